// ===== tws_slave.sv
// two-wire slave transmitter with axi4-lite registers
`timescale 1ns/100ps
module tws_slave
  import tws_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        arb_lost,
  input  wire logic        sleeping,
  output logic             wake,
  output logic             start_go,
  output logic             irq
);
  typedef enum {S_IDLE, S_ADDR, S_AACK, S_WAIT, S_TX, S_RACK, S_IGNORE} tws_state_t;

  tws_state_t state_q;
  logic [2:0] scl_sy_q, sda_sy_q;
  logic       scl_f_q, sda_f_q;
  logic [7:0] own_q, ctl_q, stat_q, data_q, shift_q, ist_q, imask_q;
  logic [3:0] bit_q;
  logic       last_q, start_pend_q, aw_q, w_q, busy_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;

  // three-stage sync, change counts once stages two and three agree
  always_ff @(posedge clk) begin
    scl_sy_q <= {scl_sy_q[1:0], scl_i};
    sda_sy_q <= {sda_sy_q[1:0], sda_i};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      if (scl_sy_q[1] == scl_sy_q[2]) scl_f_q <= scl_sy_q[2];
      if (sda_sy_q[1] == sda_sy_q[2]) sda_f_q <= sda_sy_q[2];
    end
  end
  wire scl_new  = (scl_sy_q[1] == scl_sy_q[2]) ? scl_sy_q[2] : scl_f_q;
  wire sda_new  = (sda_sy_q[1] == sda_sy_q[2]) ? sda_sy_q[2] : sda_f_q;
  wire scl_rise = scl_new & ~scl_f_q;
  wire scl_fall = ~scl_new & scl_f_q;
  wire start_c  = scl_f_q & scl_new & sda_f_q & ~sda_new;
  wire stop_c   = scl_f_q & scl_new & ~sda_f_q & sda_new;

  // register bus decode
  wire wr_go    = aw_q & w_q & ~s_axi_bvalid;
  wire rd_go    = s_axi_arvalid & s_axi_arready;
  wire wr_ctl   = wr_go & (awaddr_q == ADDR_CONTROL) & wdata_q[CTL_FLAG];
  wire wr_ctlw  = wr_go & (awaddr_q == ADDR_CONTROL);
  wire flag     = ctl_q[CTL_FLAG];
  wire ack_en   = ctl_q[CTL_ACK];
  // flag clear: software writes one to the flag bit
  wire flag_clr = wr_ctl & flag;
  wire addr_hit = (shift_q[7:1] == own_q[7:1]) | (own_q[0] & (shift_q == GEN_CALL));
  wire match    = addr_hit & ack_en & ctl_q[CTL_EN];
  wire ev_set   = (state_q == S_AACK) & scl_fall & shift_q[0] | (state_q == S_RACK) & scl_rise;
  logic [7:0] ev_code;
  assign ev_code = (state_q == S_AACK) ? (arb_lost ? ST_ARB_READ : ST_OWN_READ)
                 : sda_f_q ? ST_DATA_NACK
                 : last_q ? ST_LAST_ACK : ST_DATA_ACK;
  wire [31:0] rd_mux = (s_axi_araddr == ADDR_OWN_ADDR) ? {24'h0, own_q}
                     : (s_axi_araddr == ADDR_CONTROL) ? {24'h0, ctl_q}
                     : (s_axi_araddr == ADDR_STATUS) ? {24'h0, flag ? stat_q : ST_IDLE}
                     : (s_axi_araddr == ADDR_DATA) ? {24'h0, data_q}
                     : (s_axi_araddr == ADDR_IRQ_STAT) ? {24'h0, ist_q}
                     : (s_axi_araddr == ADDR_IRQ_MASK) ? {24'h0, imask_q} : 32'h0;
  // one decode shared by both channels, so read and write agree on the map
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == ADDR_OWN_ADDR) | (a == ADDR_CONTROL) | (a == ADDR_STATUS) |
                 (a == ADDR_DATA) | (a == ADDR_IRQ_STAT) | (a == ADDR_IRQ_MASK);
  endfunction
  wire rd_ok = reg_mapped(s_axi_araddr);
  wire wr_ok = reg_mapped(awaddr_q);
  // data written while the flag is clear during a transfer is a collision
  wire wcol = wr_go & (awaddr_q == ADDR_DATA) & ~flag & busy_q;
  wire [7:0] ev_vec = {4'h0, wcol, flag_clr & (state_q == S_IDLE), ev_set & (state_q == S_RACK),
                       ev_set & (state_q == S_AACK)};

  // axi write channel capture, either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      // readies registered: next value of the captured and response flags
      s_axi_awready <= ~(aw_q | s_axi_awvalid & s_axi_awready) & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready <= ~(w_q | s_axi_wvalid & s_axi_wready) & ~(s_axi_bvalid & ~s_axi_bready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? AXI_OKAY : AXI_SLVERR;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= ~rd_go & ~(s_axi_rvalid & ~s_axi_rready);
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // software registers; hardware set of the flag wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      own_q <= RST_OWN;
      ctl_q <= RST_CONTROL;
      data_q <= 8'h00;
      imask_q <= 8'h00;
      stat_q <= ST_IDLE;
      ist_q <= 8'h00;
    end else begin
      if (wr_go & (awaddr_q == ADDR_OWN_ADDR)) own_q <= wdata_q[7:0];
      if (wr_go & (awaddr_q == ADDR_DATA) & ~wcol) data_q <= wdata_q[7:0];
      if (wr_go & (awaddr_q == ADDR_IRQ_MASK)) imask_q <= wdata_q[7:0];
      if (wr_ctlw) begin
        ctl_q[CTL_ACK] <= wdata_q[CTL_ACK];
        ctl_q[CTL_START] <= wdata_q[CTL_START];
        ctl_q[CTL_STOP] <= wdata_q[CTL_STOP];
        ctl_q[CTL_EN] <= wdata_q[CTL_EN];
        ctl_q[CTL_IE] <= wdata_q[CTL_IE];
      end
      if (flag_clr) ctl_q[CTL_FLAG] <= 1'b0;
      if (wcol) ctl_q[CTL_WCOL] <= 1'b1;
      else if (wr_go & (awaddr_q == ADDR_DATA)) ctl_q[CTL_WCOL] <= 1'b0;
      if (start_go) ctl_q[CTL_START] <= 1'b0;
      if (ev_set) begin
        ctl_q[CTL_FLAG] <= 1'b1;
        stat_q <= ev_code;
      end
      ist_q <= (rd_go & (s_axi_araddr == ADDR_IRQ_STAT) ? 8'h00 : ist_q) | ev_vec;
    end
  end

  // bus state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= S_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      last_q <= 1'b0;
      busy_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else if (~ctl_q[CTL_EN] | stop_c) begin
      state_q <= S_IDLE;
      sda_oe <= 1'b0;
      busy_q <= 1'b0;
    end else if (start_c) begin
      state_q <= S_ADDR;
      bit_q <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE, S_IGNORE: sda_oe <= 1'b0; // master reads ones
        S_ADDR: if (scl_rise) begin
          shift_q <= {shift_q[6:0], sda_f_q};
          bit_q <= bit_q + 4'h1;
        end else if (scl_fall & (bit_q == 4'h8)) begin
          if (match) begin
            sda_oe <= 1'b1;
            state_q <= S_AACK;
          end else state_q <= S_IDLE;
        end
        S_AACK: if (scl_fall) begin
          sda_oe <= 1'b0;
          busy_q <= shift_q[0];
          state_q <= S_WAIT; // a write leaves busy_q clear, so S_WAIT returns to S_IDLE
        end
        S_WAIT: if (~flag & ~busy_q) state_q <= S_IDLE;
        else if (~flag) begin
          shift_q <= data_q;
          last_q <= ~ack_en;
          bit_q <= 4'h0;
          sda_oe <= ~data_q[7];
          state_q <= S_TX;
        end
        S_TX: if (scl_fall) begin
          if (bit_q == 4'h7) begin
            sda_oe <= 1'b0;
            state_q <= S_RACK;
          end else begin
            sda_oe <= ~shift_q[6];
            shift_q <= {shift_q[6:0], 1'b1};
            bit_q <= bit_q + 4'h1;
          end
        end
        S_RACK: if (scl_rise) state_q <= (sda_f_q | last_q) ? S_IGNORE : S_WAIT;
      endcase
    end
  end

  // stretch while the flag waits on software
  wire hold = flag & (state_q == S_WAIT | state_q == S_RACK | state_q == S_AACK) & busy_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_oe <= 1'b0;
      start_pend_q <= 1'b0;
      start_go <= 1'b0;
      wake <= 1'b0;
      irq <= 1'b0;
      // scl only ever pulled low; the level itself never changes
      scl_o <= 1'b0;
    end else begin
      scl_oe <= hold | (flag & state_q == S_WAIT);
      // latched at flag clear of c0/c8, released once the bus goes idle
      if (flag_clr & wdata_q[CTL_START] & (stat_q == ST_DATA_NACK | stat_q == ST_LAST_ACK))
        start_pend_q <= 1'b1;
      else if (start_go) start_pend_q <= 1'b0;
      start_go <= start_pend_q & (state_q == S_IDLE) & scl_f_q & sda_f_q & ~start_go;
      // data register may be stale after wake; software must not rely on it
      wake <= sleeping & ev_set & (state_q == S_AACK);
      irq <= |(ist_q & imask_q) | (flag & ctl_q[CTL_IE]);
    end
  end
  ap_status_idle_a: assert property (@(posedge clk) disable iff (rst)
    (s_axi_arvalid & s_axi_arready & s_axi_araddr == ADDR_STATUS & ~flag) |=> s_axi_rdata[7:0] == ST_IDLE)
    else $error("status not idle code");
  ap_flag_set_a: assert property (@(posedge clk) disable iff (rst)
    ev_set |=> flag) else $error("flag not set on event");
  ap_own_read_a: assert property (@(posedge clk) disable iff (rst)
    (ev_set & state_q == S_AACK & ~arb_lost) |=> stat_q == ST_OWN_READ) else $error("bad a8");
  ap_arb_read_a: assert property (@(posedge clk) disable iff (rst)
    (ev_set & state_q == S_AACK & arb_lost) |=> stat_q == ST_ARB_READ) else $error("bad b0");
  ap_nack_code_a: assert property (@(posedge clk) disable iff (rst)
    (ev_set & state_q == S_RACK & sda_f_q) |=> stat_q == ST_DATA_NACK && state_q == S_IGNORE)
    else $error("bad c0");
  ap_ack_enable_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_ADDR & ~ack_en) |=> state_q != S_AACK) else $error("acked with ack enable off");
  ap_stretch_a: assert property (@(posedge clk) disable iff (rst)
    (flag & busy_q & state_q == S_WAIT) ##1 (flag & busy_q & state_q == S_WAIT) |-> scl_oe)
    else $error("scl not held");
  ap_ignore_ones_a: assert property (@(posedge clk) disable iff (rst)
    state_q == S_IGNORE [*2] |-> ~sda_oe) else $error("driving after last byte");
  cp_tx_byte: cover property (@(posedge clk) ev_set & state_q == S_RACK & ~sda_f_q);
  cp_last_ack: cover property (@(posedge clk) ev_set & state_q == S_RACK & last_q & ~sda_f_q);
  ap_data_ack_a: assert property (@(posedge clk) disable iff (rst)
    (ev_set & state_q == S_RACK & ~sda_f_q & ~last_q) |=> stat_q == ST_DATA_ACK && state_q == S_WAIT)
    else $error("bad b8");
  ap_last_ack_a: assert property (@(posedge clk) disable iff (rst)
    (ev_set & state_q == S_RACK & ~sda_f_q & last_q) |=> stat_q == ST_LAST_ACK && state_q == S_IGNORE)
    else $error("bad c8");
  ap_foreign_addr_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_ADDR & scl_fall & bit_q == 4'h8 & ~addr_hit) |=> ~sda_oe)
    else $error("acked a foreign address");
  ap_gc_off_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_ADDR & scl_fall & bit_q == 4'h8 & shift_q == GEN_CALL & ~own_q[0] & own_q[7:1] != 7'h00)
    |=> ~sda_oe) else $error("acked general call while disabled");
  ap_own_ack_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_ADDR & scl_fall & bit_q == 4'h8 & match) |=> sda_oe && state_q == S_AACK)
    else $error("own address not acked");
  ap_ack_drive_a: assert property (@(posedge clk) disable iff (rst)
    state_q == S_AACK |-> sda_oe) else $error("ack bit not driven");
  ap_rack_free_a: assert property (@(posedge clk) disable iff (rst)
    state_q == S_RACK |-> ~sda_oe) else $error("sda driven in master ack bit");
  ap_clear_gone_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_IGNORE & flag_clr) |=> ~flag) else $error("flag not cleared when unaddressed");
  ap_start_once_a: assert property (@(posedge clk) disable iff (rst)
    start_go |=> ~start_go) else $error("start request repeated");
  ap_wake_hold_a: assert property (@(posedge clk) disable iff (rst)
    wake |=> scl_oe) else $error("scl not held after wake");
  ap_irq_level_a: assert property (@(posedge clk) disable iff (rst)
    ((ist_q & imask_q) != 8'h00) |=> irq) else $error("irq low with unmasked event");
  cp_start: cover property (@(posedge clk) start_go);
  cp_arb_read: cover property (@(posedge clk) ev_set & state_q == S_AACK & arb_lost);
  cp_wake: cover property (@(posedge clk) wake);
endmodule // tws_slave

// ===== tws_pkg.sv
// package for the two-wire slave transmitter block
package tws_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_OWN_ADDR = 8'h00;
  localparam logic [7:0] ADDR_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_DATA     = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // control bit positions
  localparam int CTL_FLAG  = 7;
  localparam int CTL_ACK   = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP  = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IE    = 0;
  // status codes
  localparam logic [7:0] ST_OWN_READ  = 8'ha8;
  localparam logic [7:0] ST_ARB_READ  = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK  = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK  = 8'hc8;
  localparam logic [7:0] ST_RECV      = 8'h60;
  localparam logic [7:0] ST_IDLE      = 8'hf8;
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_OWN      = 8'h00;
  localparam logic [7:0] GEN_CALL     = 8'h00;
  // event bits of the interrupt status register
  localparam int EV_ADDR = 0;
  localparam int EV_BYTE = 1;
  localparam int EV_DONE = 2;
  localparam int EV_W    = 3;
  typedef enum logic [1:0] {AXI_OKAY = 2'b00, AXI_SLVERR = 2'b10} tws_resp_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_line_t;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } tws_drive_t;
endpackage

// ===== tws_master_model.sv
// two-wire master receiver model for the slave transmitter bench
`timescale 1ns/100ps
module tws_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  localparam realtime Q = 31.25;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // waits while the slave stretches, so a slow slave only lengthens low
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #Q scl_low = 1'b0;
    wait (scl === 1'b1);
    #Q r = sda;
    #Q scl_low = 1'b1;
    #Q;
  endtask
  task automatic start();
    sda_low = 1'b1;
    #Q scl_low = 1'b1;
    #Q;
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(!ack, r);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q scl_low = 1'b0;
    wait (scl === 1'b1);
    #Q sda_low = 1'b0;
    #(2*Q);
  endtask
endmodule // tws_master_model

// ===== tws_slave_test.sv
// self-checking bench for the two-wire slave transmitter
`timescale 1ns/100ps
module tws_slave_test;
  import tws_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, arb_lost = 1'b0, sleeping = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic        scl_o, scl_oe, sda_o, sda_oe, wake, start_go, irq, m_scl, m_sda, a;
  logic [7:0]  v;
  int          fails = 0, num_checks = 0, wakes = 0, starts = 0;
  // open-drain lines with pull-ups
  wire         scl = !(scl_oe || m_scl);
  wire         sda = !(sda_oe || m_sda);

  tws_slave DUT (
    .clk          (clk),
    .rst          (rst),
    .s_axi_awaddr (s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata  (s_axi_wdata),
    .s_axi_wstrb  (s_axi_wstrb),
    .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready),
    .s_axi_bresp  (s_axi_bresp),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .s_axi_araddr (s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata  (s_axi_rdata),
    .s_axi_rresp  (s_axi_rresp),
    .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready),
    .scl_i        (scl),
    .scl_o        (scl_o),
    .scl_oe       (scl_oe),
    .sda_i        (sda),
    .sda_o        (sda_o),
    .sda_oe       (sda_oe),
    .arb_lost     (arb_lost),
    .sleeping     (sleeping),
    .wake         (wake),
    .start_go     (start_go),
    .irq          (irq)
  );
  tws_master_model m (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));

  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    if (wake === 1'b1) wakes++;
    if (start_go === 1'b1) starts++;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // stop request always written zero
  task automatic ctl(input logic f, ak, sr, ie);
    wr(ADDR_CONTROL, 32'(f) << CTL_FLAG | 32'(ak) << CTL_ACK | 32'(sr) << CTL_START
       | 32'h1 << CTL_EN | 32'(ie) << CTL_IE);
  endtask
  // low three status bits masked before comparing
  task automatic st(input logic [7:0] e, input bit w);
    do rd(ADDR_STATUS); while (w && (d[7:0] & 8'hf8) === ST_IDLE);
    chk("status", {24'h0, e}, {24'h0, d[7:0] & 8'hf8});
  endtask
  task automatic probe(input logic [7:0] b, input logic e);
    m.start();
    m.send(b, a);
    chk("address ack", {31'h0, e}, {31'h0, a});
    m.stop();
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    st(ST_IDLE, 0);
    rd(ADDR_CONTROL);
    chk("control", {24'h0, RST_CONTROL}, d);
    rd(8'h18);
    chk("unmapped", 32'(AXI_SLVERR), 32'(r));
    wr(8'h18, 32'h0);
    chk("unmapped write", 32'(AXI_SLVERR), 32'(r));
    wr(ADDR_IRQ_MASK, 32'h0);
    chk("write resp", 32'(AXI_OKAY), 32'(r));
    chk("scl out", 0, scl_o);
    chk("sda out", 0, sda_o);
    // general call needs its enable and ack enable
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_OWN_ADDR, 32'ha4 | 32'(i & 1));
      ctl(0, i[1], 0, 1);
      probe(GEN_CALL, i == 3);
    end
    ctl(0, 0, 0, 1);
    probe(8'ha5, 0);
    ctl(0, 1, 0, 1);
    probe(8'hb5, 0);
    // asleep, interrupt from masked event status only
    wr(ADDR_IRQ_MASK, 32'h1 << EV_ADDR);
    ctl(0, 1, 0, 0);
    @(posedge clk) sleeping <= 1'b1;
    m.start();
    m.send(8'ha5, a);
    chk("own read ack", 1, a);
    chk("wake", 1, wakes);
    repeat (20) @(posedge clk);
    chk("scl hold", 1, scl_oe);
    chk("irq", 1, irq);
    rd(ADDR_IRQ_STAT);
    chk("addr event", 1, d[EV_ADDR]);
    repeat (3) @(posedge clk);
    chk("irq cleared", 0, irq);
    @(posedge clk) sleeping <= 1'b0;
    st(ST_OWN_READ, 1);
    wr(ADDR_DATA, 32'h3c);
    ctl(1, 1, 0, 1);
    m.recv(1, v);
    chk("byte", 32'h3c, 32'(v));
    st(ST_DATA_ACK, 1);
    chk("irq flag", 1, irq);
    wr(ADDR_DATA, 32'hc5);
    ctl(1, 0, 0, 1);
    m.recv(1, v);
    chk("last byte", 32'hc5, 32'(v));
    st(ST_LAST_ACK, 1);
    ctl(1, 1, 0, 1);
    st(ST_IDLE, 0);
    m.recv(0, v);
    chk("released", 32'hff, 32'(v));
    m.stop();
    // entry after lost arbitration, then nack and start request
    @(posedge clk) arb_lost <= 1'b1;
    m.start();
    m.send(8'ha5, a);
    st(ST_ARB_READ, 1);
    @(posedge clk) arb_lost <= 1'b0;
    wr(ADDR_DATA, 32'h81);
    ctl(1, 1, 0, 1);
    m.recv(0, v);
    chk("byte", 32'h81, 32'(v));
    st(ST_DATA_NACK, 1);
    ctl(1, 1, 1, 1);
    chk("start early", 0, starts);
    m.stop();
    repeat (50) @(posedge clk);
    chk("start", 1, starts);
    ctl(0, 1, 0, 1);
    m.start();
    m.send(8'ha5, a);
    chk("readdressed", 1, a);
    st(ST_OWN_READ, 1);
    ctl(1, 0, 0, 1);
    m.recv(0, v);
    st(ST_DATA_NACK, 1);
    ctl(1, 0, 0, 1);
    m.stop();
    probe(8'ha5, 0);
    end_of_test();
  end
endmodule // tws_slave_test
